//--- logic/ftm_defs.svh
// Purpose: constants for the fan speed monitor control block
// Assumes: 32-bit axi4-lite register word, 50 MHz aclk
// Notes: offsets are byte addresses
`ifndef FTM_DEFS_SVH
`define FTM_DEFS_SVH
`define FTM_OFF_CTRL 4'h0
`define FTM_OFF_STAT 4'h4
`define FTM_OFF_HIGH 4'h8
`define FTM_OFF_LOW 4'hC
`define FTM_OFF_MASK 4'h0
`define FTM_BIT_LIM_IRQ 0
`define FTM_BIT_ENABLE 1
`define FTM_BIT_FILTER 8
`define FTM_BIT_MODE 10
`define FTM_EDGES_LO 11
`define FTM_BIT_RDY_IRQ 14
`define FTM_BIT_TOG_IRQ 15
`define FTM_CTRL_WMASK 32'h0000DD03
`define FTM_STAT_LIMIT 0
`define FTM_STAT_PIN 1
`define FTM_STAT_TOGGLE 2
`define FTM_STAT_READY 3
`define FTM_HIGH_RESET 16'hFFFF
`define FTM_LOW_RESET 16'h0000
`define FTM_CLK_HZ 50000000
`define FTM_REF_HZ 100000
`define FTM_REF_DIV (`FTM_CLK_HZ / `FTM_REF_HZ)
`define FTM_FILTER_TICKS 2
`define FTM_RESP_OKAY 2'h0
`define FTM_RESP_SLVERR 2'h2
`endif

//--- logic/ftm_pkg.sv
// Purpose: types for the fan speed monitor control block
// Assumes: nothing beyond ftm_defs.svh
// Notes: state of the top is one struct
package ftm_pkg;
    typedef enum logic [1:0] {
        FTM_WR_IDLE = 2'h1,
        FTM_WR_RESP = 2'h2
    } ftm_wr_state_t;
    typedef struct packed {
        ftm_wr_state_t wr_state;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [3:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] ctrl;
        logic [15:0] latched;
        logic [15:0] counter;
        logic [3:0] edge_cnt;
        logic [15:0] high_lim;
        logic [15:0] low_lim;
        logic [3:0] status;
        logic irq;
        logic pin_oe;
        logic [8:0] ref_div;
        logic tach_prev;
    } ftm_state_t;
endpackage : ftm_pkg

//--- logic/ftm_glitch_filter.sv
// Purpose: removes tach pulses narrower than a set number of reference ticks
// Assumes: tick is a one-cycle enable at the reference rate
// Notes: while disabled the input passes straight through
`timescale 1ns/1ns
`default_nettype none
module ftm_glitch_filter #(
    parameter int TICKS = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic tick,
    input wire logic filter_on,
    input wire logic raw_in,
    output logic filt_out
);
    logic stable_q;
    logic [2:0] agree_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_q <= 1'b0;
            agree_q <= 3'h0;
        end else if (!filter_on) begin
            stable_q <= raw_in;
            agree_q <= 3'h0;
        end else if (run) begin
            // level must hold for TICKS reference edges before it is accepted
            if (raw_in == stable_q) begin
                agree_q <= 3'h0;
            end else if (tick) begin
                if (agree_q >= 3'(TICKS - 1)) begin
                    stable_q <= raw_in;
                    agree_q <= 3'h0;
                end else begin
                    agree_q <= agree_q + 3'h1;
                end
            end
        end
    end
    assign filt_out = filter_on ? stable_q : raw_in;
endmodule : ftm_glitch_filter
`default_nettype wire

//--- logic/ftm_monitor.sv
// Purpose: fan speed monitor control, counter and axi4-lite register slave
// Assumes: speed_sense_pin_i synchronous to aclk; one outstanding read and write
// Notes: clock gating is modelled as a run enable on all counting state
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ftm_defs.svh"
module ftm_monitor #(
    parameter int REF_DIV = `FTM_REF_DIV,
    parameter int FILTER_TICKS = `FTM_FILTER_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic speed_sense_pin_i,
    output logic speed_sense_pin_oe,
    output logic irq
);
    ftm_pkg::ftm_state_t s_q;
    ftm_pkg::ftm_state_t s_d;
    logic tach_filt;
    logic ref_tick;
    logic run;
    logic [31:0] ctrl_word;
    logic [31:0] wmask;

    assign run = s_q.ctrl[`FTM_BIT_ENABLE];
    assign ref_tick = run && (s_q.ref_div == 9'(REF_DIV - 1));
    assign ctrl_word = {s_q.latched, s_q.ctrl};
    assign wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
                    {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};

    ftm_glitch_filter #(
        .TICKS(FILTER_TICKS)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .tick(ref_tick),
        .filter_on(s_q.ctrl[`FTM_BIT_FILTER]),
        .raw_in(speed_sense_pin_i),
        .filt_out(tach_filt)
    );

    function automatic logic [3:0] edge_target(input logic [1:0] sel);
        logic [3:0] t;
        t = 4'h2;
        case (sel)
            2'h0: t = 4'h2;
            2'h1: t = 4'h3;
            2'h2: t = 4'h5;
            default: t = 4'h9;
        endcase
        return t;
    endfunction : edge_target

    always_comb begin
        logic rise;
        logic toggle;
        logic latch_now;
        logic [15:0] new_read;
        logic [31:0] wr_val;
        logic [3:0] clr;
        rise = 1'b0;
        toggle = 1'b0;
        latch_now = 1'b0;
        new_read = s_q.latched;
        wr_val = 32'h0;
        clr = 4'h0;
        s_d = s_q;

        // counting state only moves while enabled, so it resumes where it left off
        if (run) begin
            rise = tach_filt && !s_q.tach_prev;
            toggle = tach_filt != s_q.tach_prev;
            s_d.tach_prev = tach_filt;
            s_d.ref_div = ref_tick ? 9'h0 : s_q.ref_div + 9'h1;
            if (!s_q.ctrl[`FTM_BIT_MODE]) begin
                if (rise) begin
                    s_d.counter = s_q.counter + 16'h1;
                    new_read = s_q.counter + 16'h1;
                    latch_now = 1'b1;
                end
            end else begin
                if (ref_tick && s_q.counter != 16'hFFFF) begin
                    s_d.counter = s_q.counter + 16'h1;
                end
                if (rise) begin
                    s_d.edge_cnt = s_q.edge_cnt + 4'h1;
                end
                // edges counted on any transition; FFFF marks a stalled fan
                if (toggle) begin
                    if (s_q.edge_cnt + 4'h1 >= edge_target(s_q.ctrl[12:11])) begin
                        latch_now = 1'b1;
                    end
                    s_d.edge_cnt = s_q.edge_cnt + 4'h1;
                end
                if (!latch_now && s_q.counter == 16'hFFFF) begin
                    latch_now = 1'b1;
                end
                if (latch_now) begin
                    new_read = s_q.counter;
                    s_d.counter = 16'h0;
                    s_d.edge_cnt = 4'h0;
                end
            end
        end
        if (latch_now) begin
            s_d.latched = new_read;
        end

        // write channel: address and data taken in either order
        if (s_q.awready && s_axi_awvalid) begin
            s_d.awready = 1'b0;
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.wready = 1'b0;
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        case (s_q.wr_state)
            ftm_pkg::FTM_WR_IDLE: begin
                if (s_q.aw_got && s_q.w_got) begin
                    s_d.aw_got = 1'b0;
                    s_d.w_got = 1'b0;
                    s_d.bvalid = 1'b1;
                    s_d.bresp = `FTM_RESP_OKAY;
                    s_d.wr_state = ftm_pkg::FTM_WR_RESP;
                    wr_val = s_q.w_data & wmask;
                    if (s_q.aw_addr[3:2] == 2'(`FTM_OFF_CTRL >> 2)) begin
                        // bytes whose strobe is low keep their old value
                        s_d.ctrl = (s_q.ctrl & ~(wmask[15:0] & 16'(`FTM_CTRL_WMASK)))
                                 | (s_q.w_data[15:0] & wmask[15:0]
                                    & 16'(`FTM_CTRL_WMASK));
                    end else if (s_q.aw_addr[3:2] == 2'(`FTM_OFF_STAT >> 2)) begin
                        clr = {wr_val[`FTM_STAT_READY], wr_val[`FTM_STAT_TOGGLE],
                               1'b0, wr_val[`FTM_STAT_LIMIT]};
                    end else if (s_q.aw_addr[3:2] == 2'(`FTM_OFF_HIGH >> 2)) begin
                        s_d.high_lim = (s_q.high_lim & ~wmask[15:0]) | wr_val[15:0];
                    end else begin
                        s_d.low_lim = (s_q.low_lim & ~wmask[15:0]) | wr_val[15:0];
                    end
                end
            end
            ftm_pkg::FTM_WR_RESP: begin
                if (s_axi_bready) begin
                    s_d.bvalid = 1'b0;
                    s_d.awready = 1'b1;
                    s_d.wready = 1'b1;
                    s_d.wr_state = ftm_pkg::FTM_WR_IDLE;
                end
            end
            default: begin
                s_d.wr_state = ftm_pkg::FTM_WR_IDLE;
            end
        endcase

        // status: hardware set wins over a same-cycle write-one clear
        s_d.status = s_q.status & ~clr;
        s_d.status[`FTM_STAT_PIN] = speed_sense_pin_i;
        if (toggle) begin
            s_d.status[`FTM_STAT_TOGGLE] = 1'b1;
        end
        if (latch_now && s_q.ctrl[`FTM_BIT_MODE]) begin
            s_d.status[`FTM_STAT_READY] = 1'b1;
        end
        if (latch_now && (new_read > s_q.high_lim || new_read < s_q.low_lim)) begin
            s_d.status[`FTM_STAT_LIMIT] = 1'b1;
        end

        // read channel: one read in flight, unmapped offsets cannot occur in 4 bits
        if (s_q.arready && s_axi_arvalid) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = `FTM_RESP_OKAY;
            if (s_axi_araddr[3:2] == 2'(`FTM_OFF_CTRL >> 2)) begin
                s_d.rdata = ctrl_word;
            end else if (s_axi_araddr[3:2] == 2'(`FTM_OFF_STAT >> 2)) begin
                s_d.rdata = {28'h0, s_q.status};
            end else if (s_axi_araddr[3:2] == 2'(`FTM_OFF_HIGH >> 2)) begin
                s_d.rdata = {16'h0, s_q.high_lim};
            end else begin
                s_d.rdata = {16'h0, s_q.low_lim};
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // interrupt drawn from the registered status, so it trails a status set by one cycle
        s_d.irq = (s_q.status[`FTM_STAT_LIMIT] && s_q.ctrl[`FTM_BIT_LIM_IRQ])
                | (s_q.status[`FTM_STAT_READY] && s_q.ctrl[`FTM_BIT_RDY_IRQ])
                | (s_q.status[`FTM_STAT_TOGGLE] && s_q.ctrl[`FTM_BIT_TOG_IRQ]);
        // the monitor only ever receives on the pin, so it never drives it
        s_d.pin_oe = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.wr_state <= ftm_pkg::FTM_WR_IDLE;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.high_lim <= `FTM_HIGH_RESET;
            s_q.low_lim <= `FTM_LOW_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign speed_sense_pin_oe = s_q.pin_oe;
    assign irq = s_q.irq;
endmodule : ftm_monitor
`default_nettype wire

//--- verif/ftm_monitor_checker.sv
// Purpose: port assertions for ftm_monitor
// Assumes: aw and w offered together
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module ftm_monitor_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic speed_sense_pin_oe,
    input wire logic irq
);
    logic wt;
    logic [15:0] ctl_q;
    logic [3:0] ra_q;
    assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shadow of control, leads the design by its write latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= 16'h0000;
            ra_q <= 4'h0;
        end else begin
            if (wt && s_axi_awaddr == 4'h0) begin
                if (s_axi_wstrb[0])
                    ctl_q[7:0] <= s_axi_wdata[7:0];
                if (s_axi_wstrb[1])
                    ctl_q[15:8] <= s_axi_wdata[15:8];
            end
            if (s_axi_arvalid && s_axi_arready)
                ra_q <= s_axi_araddr;
        end
    end
    sequence s_wr; wt; endsequence
    sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
    property p_oe_off; !speed_sense_pin_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("tach pin driven");
    property p_rst_irq; $rose(aresetn) |-> !irq; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
    property p_irq_masked; (ctl_q[0] == 1'b0 && ctl_q[15:14] == 2'h0) [*4] |-> !irq; endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
    property p_idle; (!ctl_q[1] && !wt) [*4] |-> !$rose(irq); endproperty
    a_idle: assert property (p_idle) else $error("event while idle");
    property p_resv; s_axi_rvalid && ra_q == 4'h0 |-> (s_axi_rdata & 32'h000022FC) == 32'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_rd_ans; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_wr_ans; s_wr |-> ##2 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_okay; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
    a_okay: assert property (p_okay) else $error("bad write response");
endmodule : ftm_monitor_checker
bind ftm_monitor ftm_monitor_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .speed_sense_pin_oe, .irq);
`default_nettype wire

//--- verif/ftm_fan_model.sv
// Purpose: fan tach output for the monitor bench
// Assumes: widths are whole aclk cycles
// Notes: line rests low; bench keeps it low before a pulse
`timescale 1ns/1ns
`default_nettype none
module ftm_fan_model (
    input wire logic aclk,
    output logic tach
);
    initial tach = 1'b0;
    task automatic pulse(input int hi, input int lo);
        repeat (lo) @(posedge aclk);
        tach <= 1'b1;
        repeat (hi) @(posedge aclk);
        tach <= 1'b0;
    endtask : pulse
    task automatic flip(input int gap);
        repeat (gap) @(posedge aclk);
        tach <= ~tach;
    endtask : flip
endmodule : ftm_fan_model
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench for ftm_monitor
// Assumes: REF_DIV of 4, so the filter window is 8 aclk
// Notes: tach comes from ftm_fan_model
`timescale 1ns/1ns
`default_nettype none
`define CHK(w, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", w, e, g); end end
module tb;
    logic aclk, aresetn, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy, oe, irq, tach;
    logic [3:0] awa, ara, ws;
    logic [31:0] wd, rdat;
    int miscompares = 0;
    int cmp_count = 0;
    ftm_monitor #(.REF_DIV(4)) dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .speed_sense_pin_i(tach),
        .speed_sense_pin_oe(oe), .irq);
    ftm_fan_model fan (.aclk, .tach);
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic till(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== 1'b1 && n < 50);
        if (s !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
    endtask : till
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic aw_done;
        logic w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        // each channel is released at the edge that takes it
        while (!(aw_done && w_done) && n < 50) begin
            @(posedge aclk);
            n++;
            if (!aw_done && awr === 1'b1) begin
                aw_done = 1'b1;
                awv <= 1'b0;
            end
            if (!w_done && wrdy === 1'b1) begin
                w_done = 1'b1;
                wv <= 1'b0;
            end
        end
        if (!(aw_done && w_done)) begin
            miscompares++;
            wrap_up();
        end
        till(bv);
        brdy <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        till(arr);
        arv <= 1'b0;
        till(rv);
        rrdy <= 1'b0;
        d = rdat;
    endtask : rd
    task automatic lat(input logic [15:0] e);
        logic [31:0] v;
        rd(4'h0, v);
        `CHK("latched count", e, v[31:16])
    endtask : lat
    task automatic t_reset();
        logic [31:0] v;
        rd(4'h0, v);
        `CHK("ctrl reset", 32'h00000000, v)
        wr(4'h0, 32'hFFFFFFFD);
        rd(4'h0, v);
        `CHK("ctrl fields", 32'h0000DD01, v)
        ws <= 4'h1;
        wr(4'h0, 32'h00000000);
        ws <= 4'hF;
        rd(4'h0, v);
        `CHK("ctrl byte strobe", 32'h0000DD00, v)
        wr(4'h0, 32'h00000000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_mode0();
        wr(4'h0, 32'h00000002);
        repeat (3) fan.pulse(3, 10);
        lat(16'h0003);
        wr(4'h0, 32'h00000000);
        repeat (2) fan.pulse(3, 10);
        lat(16'h0003);
        `CHK("pin tristate", 1'b0, oe)
        wr(4'h0, 32'h00000102);
        fan.pulse(3, 30);
        lat(16'h0003);
        fan.pulse(30, 30);
        lat(16'h0004);
        $display("t_mode0 done");
    endtask : t_mode0
    task automatic t_mode1();
        logic [31:0] v;
        int e;
        for (int c = 0; c < 4; c++) begin
            e = (c == 3) ? 9 : (c == 2) ? 5 : c + 2;
            wr(4'h0, 32'h00000502 | (32'(c) << 11));
            wr(4'h4, 32'h0000000D);
            v = 32'h0;
            for (int n = 0; n < 12 && v[3] !== 1'b1; n++) begin
                fan.flip(40);
                repeat (16) @(posedge aclk);
                rd(4'h4, v);
            end
            `CHK("ready sync", 1'b1, v[3])
            // first window starts at an unknown phase and is discarded
            repeat (2 * e) fan.flip(40);
            repeat (16) @(posedge aclk);
            rd(4'h0, v);
            `CHK("window ticks", 1'b1, v[31:16] - 16'(10 * e - 1) <= 16'h0002)
        end
        $display("t_mode1 done");
    endtask : t_mode1
    task automatic t_irq();
        logic [31:0] v;
        if (tach === 1'b1)
            fan.flip(1);
        wr(4'h8, 32'h00000000);
        wr(4'h0, 32'h00000002);
        fan.pulse(30, 30);
        rd(4'h4, v);
        `CHK("limit flag", 1'b1, v[0])
        `CHK("irq masked", 1'b0, irq)
        wr(4'h0, 32'h00000003);
        repeat (4) @(posedge aclk);
        `CHK("irq on", 1'b1, irq)
        wr(4'h4, 32'h00000001);
        repeat (4) @(posedge aclk);
        `CHK("irq cleared", 1'b0, irq)
        wr(4'h8, 32'h0000FFFF);
        wr(4'hC, 32'h0000FFFF);
        fan.pulse(30, 30);
        rd(4'h4, v);
        `CHK("low limit flag", 1'b1, v[0])
        repeat (4) @(posedge aclk);
        `CHK("irq low limit", 1'b1, irq)
        $display("t_irq done");
    endtask : t_irq
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        {awv, wv, brdy, arv, rrdy} = 5'h00;
        {awa, ara, wd} = 40'h0;
        ws = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mode0();
        t_mode1();
        t_irq();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
